// ---- hw/pwr_state_pkg.sv ----
// shared constants, states and carrier types for the power-state control block
package pwr_state_pkg;

    // system clock
    localparam int CLK_FREQ_MHZ = 100;
    localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;

    // pin group widths
    localparam int DATA_W = 16;
    localparam int PARITY_W = 2;
    localparam int UADDR_W = 28;

    // input clock counted as stopped after this long with no rising edge (least time, rounds up)
    localparam int CLK_LOSS_NS = 640;
    localparam int CLK_LOSS_CYCLES = (CLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // return from stop clock: input clock periods allowed, and edges actually counted
    localparam int RESTART_MAX_PERIODS = 8;
    localparam int RESTART_EDGES = 4;

    // values after reset
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [PARITY_W-1:0] PARITY_RESET = 2'h0;
    localparam logic [UADDR_W-1:0] UADDR_RESET = 28'h0000000;

    // power states, one-hot
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_STOP_GRANT = 3'b010,
        ST_STOP_CLOCK = 3'b100
    } pwr_state_t;

    // what the processor core wants on the pins in normal execution
    typedef struct packed {
        logic [UADDR_W-1:0] addr;
        logic addr_oe;
        logic [DATA_W-1:0] data;
        logic [PARITY_W-1:0] parity;
        logic data_oe;
    } core_bus_t;

endpackage

// ---- hw/pin_keeper.sv ----
// level keeper for a group of two-way pins
`timescale 1ns/100ps
module pin_keeper #(
    parameter int W = 16,
    parameter logic [W-1:0] RESET_LEVEL = '0
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_pin,
    input wire logic i_drive,
    input wire logic [W-1:0] i_drive_data,
    input wire logic i_keep,
    input wire logic i_float,
    output logic [W-1:0] o_pin,
    output logic [W-1:0] o_oe
);

    logic [W-1:0] pin_meta_r;
    logic [W-1:0] pin_sync_r;
    logic [W-1:0] level_r;
    logic [2:0] float_hist_r;

    ////////////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser on the pin levels
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_meta_r <= RESET_LEVEL;
            pin_sync_r <= RESET_LEVEL;
        end else begin
            pin_meta_r <= i_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    // remembers a recent float or own drive; the readback lags the pins by three cycles
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            float_hist_r <= 3'h0;
        end else begin
            float_hist_r <= {float_hist_r[1:0], i_float || i_drive};
        end
    end

    // kept level: own driven data, else the latest level seen, frozen while readback is stale
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            level_r <= RESET_LEVEL;
        end else if (i_float) begin
            level_r <= level_r;
        end else if (i_drive) begin
            level_r <= i_drive_data;
        end else if (float_hist_r != 3'h0) begin
            level_r <= level_r;
        end else begin
            level_r <= pin_sync_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin drivers; an outside driver overpowers the weak keep and the level follows it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin <= RESET_LEVEL;
            o_oe <= '0;
        end else begin
            o_pin <= i_drive ? i_drive_data : level_r;
            o_oe <= {W{(i_drive || i_keep) && !i_float}};
        end
    end

endmodule // pin_keeper

// ---- hw/stop_clock_power_state_control.sv ----
// normal, stop grant and stop clock state control with pin keeping
`timescale 1ns/100ps
module stop_clock_power_state_control
    import pwr_state_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_stop_clock_request_n,
    input wire logic i_input_clock,
    input wire logic i_hold,
    input wire logic i_bus_idle,
    input wire pwr_state_pkg::core_bus_t i_core,
    input wire logic [pwr_state_pkg::DATA_W-1:0] i_data_bus_pins,
    input wire logic [pwr_state_pkg::PARITY_W-1:0] i_data_parity_pins,
    output logic [pwr_state_pkg::DATA_W-1:0] o_data_bus_pins,
    output logic [pwr_state_pkg::DATA_W-1:0] o_data_bus_oe,
    output logic [pwr_state_pkg::PARITY_W-1:0] o_data_parity_pins,
    output logic [pwr_state_pkg::PARITY_W-1:0] o_data_parity_oe,
    output logic [pwr_state_pkg::UADDR_W-1:0] o_upper_address_lines,
    output logic o_upper_address_oe,
    output logic o_hold_acknowledge,
    output logic o_stop_grant,
    output logic o_stop_clock,
    output logic o_core_run
);
    import pwr_state_pkg::*;

    localparam int IDLE_W = $clog2(CLK_LOSS_CYCLES + 1);
    localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(CLK_LOSS_CYCLES);
    localparam logic [3:0] EDGE_LAST = 4'(RESTART_EDGES - 1);

    pwr_state_t state_r;
    pwr_state_t state_nxt;
    logic stop_meta_r;
    logic stop_sync_n_r;
    logic hold_meta_r;
    logic hold_sync_r;
    logic iclk_meta_r;
    logic iclk_sync_r;
    logic iclk_prev_r;
    logic iclk_edge;
    logic [IDLE_W-1:0] idle_cnt_r;
    logic clk_lost;
    logic [3:0] edge_cnt_r;
    logic hold_ack_nxt;
    logic uaddr_oe_held_r;
    logic data_keep;
    logic float_pins;

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers for the pins from outside the clock domain
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stop_meta_r <= 1'b1;
            stop_sync_n_r <= 1'b1;
        end else begin
            stop_meta_r <= i_stop_clock_request_n;
            stop_sync_n_r <= stop_meta_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_meta_r <= 1'b0;
            hold_sync_r <= 1'b0;
        end else begin
            hold_meta_r <= i_hold;
            hold_sync_r <= hold_meta_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            iclk_meta_r <= 1'b0;
            iclk_sync_r <= 1'b0;
            iclk_prev_r <= 1'b0;
        end else begin
            iclk_meta_r <= i_input_clock;
            iclk_sync_r <= iclk_meta_r;
            iclk_prev_r <= iclk_sync_r;
        end
    end

    // rising edge of the processor input clock
    assign iclk_edge = iclk_sync_r && !iclk_prev_r;

    ////////////////////////////////////////////////////////////////////////////////
    // input clock watch: cycles since the last edge, saturating
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idle_cnt_r <= '0;
        end else if (iclk_edge) begin
            idle_cnt_r <= '0;
        end else if (idle_cnt_r != IDLE_MAX) begin
            idle_cnt_r <= idle_cnt_r + IDLE_W'(1);
        end
    end

    assign clk_lost = (idle_cnt_r == IDLE_MAX);

    // edges seen since the clock came back while in stop clock
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            edge_cnt_r <= 4'h0;
        end else if (state_r != ST_STOP_CLOCK) begin
            edge_cnt_r <= 4'h0;
        end else if (iclk_edge) begin
            edge_cnt_r <= edge_cnt_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power state transitions
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (!stop_sync_n_r && i_bus_idle) begin
                    state_nxt = ST_STOP_GRANT;
                end
            end
            ST_STOP_GRANT: begin
                if (o_hold_acknowledge) begin
                    state_nxt = ST_STOP_GRANT;
                end else if (stop_sync_n_r) begin
                    state_nxt = ST_NORMAL;
                end else if (clk_lost) begin
                    state_nxt = ST_STOP_CLOCK;
                end
            end
            ST_STOP_CLOCK: begin
                if (iclk_edge && edge_cnt_r == EDGE_LAST) begin
                    state_nxt = ST_STOP_GRANT;
                end
            end
            default: begin
                state_nxt = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= ST_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // state indications to the core and to the outside system
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_stop_grant <= 1'b0;
            o_stop_clock <= 1'b0;
            o_core_run <= 1'b1;
        end else begin
            o_stop_grant <= (state_nxt == ST_STOP_GRANT);
            o_stop_clock <= (state_nxt == ST_STOP_CLOCK);
            o_core_run <= (state_nxt == ST_NORMAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus hold in stop grant only while the input clock runs
    assign hold_ack_nxt = (state_nxt == ST_STOP_GRANT) && hold_sync_r && !clk_lost;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hold_acknowledge <= 1'b0;
        end else begin
            o_hold_acknowledge <= hold_ack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // upper address lines: follow the core in normal, frozen in the low-power states
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_upper_address_lines <= UADDR_RESET;
            uaddr_oe_held_r <= 1'b0;
        end else if (state_nxt == ST_NORMAL) begin
            o_upper_address_lines <= i_core.addr;
            uaddr_oe_held_r <= i_core.addr_oe;
        end else begin
            o_upper_address_lines <= o_upper_address_lines;
            uaddr_oe_held_r <= uaddr_oe_held_r;
        end
    end

    // address drivers float during hold and come back with the held level
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_upper_address_oe <= 1'b0;
        end else if (state_nxt == ST_NORMAL) begin
            o_upper_address_oe <= i_core.addr_oe;
        end else begin
            o_upper_address_oe <= uaddr_oe_held_r && !hold_ack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data and parity keepers
    assign data_keep = (state_nxt != ST_NORMAL);
    assign float_pins = hold_ack_nxt;

    pin_keeper #(
        .W(DATA_W),
        .RESET_LEVEL(DATA_RESET)
    ) u_data_keeper (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_data_bus_pins),
        .i_drive(i_core.data_oe && state_nxt == ST_NORMAL),
        .i_drive_data(i_core.data),
        .i_keep(data_keep),
        .i_float(float_pins),
        .o_pin(o_data_bus_pins),
        .o_oe(o_data_bus_oe)
    );

    pin_keeper #(
        .W(PARITY_W),
        .RESET_LEVEL(PARITY_RESET)
    ) u_parity_keeper (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_data_parity_pins),
        .i_drive(i_core.data_oe && state_nxt == ST_NORMAL),
        .i_drive_data(i_core.parity),
        .i_keep(1'b1),
        .i_float(float_pins),
        .o_pin(o_data_parity_pins),
        .o_oe(o_data_parity_oe)
    );

endmodule // stop_clock_power_state_control

// ---- verification/stop_clock_power_state_control_chk.sv ----
// assertion checker for the power-state control block
`timescale 1ns/100ps
module stop_clock_power_state_control_chk
    import pwr_state_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_stop_clock_request_n,
    input wire logic i_input_clock,
    input wire logic i_bus_idle,
    input wire logic [pwr_state_pkg::DATA_W-1:0] i_data_bus_pins,
    input wire logic [pwr_state_pkg::DATA_W-1:0] o_data_bus_pins,
    input wire logic [pwr_state_pkg::DATA_W-1:0] o_data_bus_oe,
    input wire logic [pwr_state_pkg::PARITY_W-1:0] o_data_parity_oe,
    input wire logic [pwr_state_pkg::UADDR_W-1:0] o_upper_address_lines,
    input wire logic o_upper_address_oe,
    input wire logic o_hold_acknowledge,
    input wire logic o_stop_grant,
    input wire logic o_stop_clock,
    input wire logic o_core_run
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic lp;
    logic ic_r;
    logic [3:0] kcnt;
    logic [4:0] rcnt;
    assign lp = o_stop_grant | o_stop_clock;
    ////////////////////////////////////////////////////////////////////////////////
    // cycles of steady keeping with no hold
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            kcnt <= 4'h0;
        end else if (!lp || o_hold_acknowledge) begin
            kcnt <= 4'h0;
        end else if (kcnt != 4'hf) begin
            kcnt <= kcnt + 4'h1;
        end
    end
    // raw input clock rises seen while stopped
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ic_r <= 1'b0;
            rcnt <= 5'h00;
        end else begin
            ic_r <= i_input_clock;
            rcnt <= o_stop_clock ? rcnt + {4'h0, i_input_clock & ~ic_r} : 5'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_parity_keep_on: assert property ($past(i_reset_n) && !o_hold_acknowledge
        && !$past(o_hold_acknowledge) |-> o_data_parity_oe == '1) else $error("parity keeper off");
    a_data_keep_on: assert property (lp && $past(lp) && !o_hold_acknowledge
        && !$past(o_hold_acknowledge) |-> o_data_bus_oe == '1) else $error("data keeper off");
    a_keep_follows_pin: assert property (lp && kcnt > 4'h5 && $changed(o_data_bus_pins)
        |-> o_data_bus_pins == $past(i_data_bus_pins, 4)) else $error("kept level wrong");
    a_addr_prev_state: assert property (lp && $past(lp) && !o_hold_acknowledge
        && !$past(o_hold_acknowledge) && !$past(o_hold_acknowledge, 2)
        |-> $stable(o_upper_address_lines) && $stable(o_upper_address_oe))
        else $error("address moved in low power");
    a_req_sync_delay: assert property ($fell(i_stop_clock_request_n) && o_core_run && i_bus_idle
        |-> !o_stop_grant [*2] ##[1:2] o_stop_grant) else $error("stop grant timing");
    a_release_resume: assert property ($rose(i_stop_clock_request_n) && o_stop_grant
        && !o_hold_acknowledge |-> ##[1:4] o_core_run) else $error("no resume");
    a_restart_bound: assert property (o_stop_clock |-> rcnt <= 5'd8)
        else $error("restart too slow");
    a_hold_float: assert property (o_hold_acknowledge |-> o_data_bus_oe == '0
        && o_data_parity_oe == '0 && !o_upper_address_oe && !o_core_run) else $error("hold not floated");
endmodule // stop_clock_power_state_control_chk

bind stop_clock_power_state_control stop_clock_power_state_control_chk u_chk (.i_clk, .i_reset_n,
    .i_stop_clock_request_n, .i_input_clock, .i_bus_idle, .i_data_bus_pins, .o_data_bus_pins,
    .o_data_bus_oe, .o_data_parity_oe, .o_upper_address_lines, .o_upper_address_oe,
    .o_hold_acknowledge, .o_stop_grant, .o_stop_clock, .o_core_run);

// ---- verification/sys_pm_model.sv ----
// external clock and power-management partner model
`timescale 1ns/100ps
module sys_pm_model (
    input wire logic i_stop_grant,
    output logic o_stop_clock_request_n,
    output logic o_input_clock
);
    int half_ns = 20;
    logic run = 1'b1;
    initial o_stop_clock_request_n = 1'b1;
    initial o_input_clock = 1'b0;
    // input clock, period fixed between rate changes, parked low when stopped
    always #(half_ns) if (run) o_input_clock = ~o_input_clock;
    task automatic set_req(input logic v);
        o_stop_clock_request_n = v;
    endtask
    // rate change only once stop grant is shown
    task automatic new_rate(input int h);
        wait (i_stop_grant === 1'b1);
        half_ns = h;
    endtask
    // nine rising edges give eight whole periods at the new rate before release
    task automatic release_req();
        repeat (9) @(posedge o_input_clock);
        o_stop_clock_request_n = 1'b1;
    endtask
    // clock is stopped only in stop grant
    task automatic stop_clk();
        wait (i_stop_grant === 1'b1);
        @(negedge o_input_clock);
        run = 1'b0;
    endtask
    task automatic start_clk();
        run = 1'b1;
    endtask
endmodule // sys_pm_model

// ---- verification/stop_clock_power_state_control_test.sv ----
// self-checking testbench for the power-state control block
`timescale 1ns/100ps
module stop_clock_power_state_control_test;
    import pwr_state_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_hold = 1'b0;
    logic i_bus_idle = 1'b1;
    logic ext_en = 1'b0;
    logic [15:0] ext_d = 16'h0000;
    logic [1:0] ext_p = 2'h0;
    core_bus_t i_core = '0;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    wire [15:0] data_o, data_oe, data_w;
    wire [1:0] par_o, par_oe, par_w;
    wire [27:0] addr_o;
    wire addr_oe, hold_ack, grant, stopped, core_run, req_n, in_clk;
    // outside driver wins over the weak keeper; undriven bits read inverted
    assign data_w = ext_en ? ext_d : ~(data_oe ^ data_o);
    assign par_w = ext_en ? ext_p : ~(par_oe ^ par_o);
    stop_clock_power_state_control DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_stop_clock_request_n(req_n), .i_input_clock(in_clk), .i_hold(i_hold),
        .i_bus_idle(i_bus_idle), .i_core(i_core), .i_data_bus_pins(data_w),
        .i_data_parity_pins(par_w), .o_data_bus_pins(data_o), .o_data_bus_oe(data_oe),
        .o_data_parity_pins(par_o), .o_data_parity_oe(par_oe), .o_upper_address_lines(addr_o),
        .o_upper_address_oe(addr_oe), .o_hold_acknowledge(hold_ack), .o_stop_grant(grant),
        .o_stop_clock(stopped), .o_core_run(core_run));
    sys_pm_model pm (.i_stop_grant(grant), .o_stop_clock_request_n(req_n), .o_input_clock(in_clk));
    always #5 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic grant_in();
        pm.set_req(1'b0);
        for (int i = 0; i < 12 && grant !== 1'b1; i++) step();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_normal();
        i_core = '{28'h1234567, 1'b1, 16'ha5c3, 2'h2, 1'b1};
        i_hold = 1'b1;
        repeat (6) step();
        chk({data_oe, data_o, par_o}, {16'hffff, 16'ha5c3, 2'h2});
        chk({hold_ack, core_run}, 2'h1);
        i_hold = 1'b0;
        $display("normal done");
    endtask
    task automatic t_grant();
        i_bus_idle = 1'b0;
        pm.set_req(1'b0);
        repeat (8) step();
        chk(core_run, 1'b1);
        i_bus_idle = 1'b1;
        grant_in();
        i_core = '{28'h0fedcba, 1'b1, 16'h0000, 2'h0, 1'b1};
        repeat (4) step();
        chk({grant, core_run}, 2'h2);
        chk({addr_oe, addr_o}, {1'b1, 28'h1234567});
        chk({data_oe, data_o, par_o}, {16'hffff, 16'ha5c3, 2'h2});
        $display("grant done");
    endtask
    task automatic t_flip();
        ext_d = 16'h5a0f;
        ext_p = 2'h1;
        ext_en = 1'b1;
        repeat (6) step();
        ext_en = 1'b0;
        repeat (4) step();
        chk({data_o, par_o, par_oe}, {16'h5a0f, 2'h1, 2'h3});
        $display("flip done");
    endtask
    task automatic t_hold();
        i_hold = 1'b1;
        for (int i = 0; i < 10 && hold_ack !== 1'b1; i++) step();
        chk({hold_ack, data_oe, par_oe, addr_oe}, {1'b1, 19'h0});
        i_hold = 1'b0;
        for (int i = 0; i < 10 && hold_ack !== 1'b0; i++) step();
        repeat (4) step();
        chk({data_oe, data_o, par_o, addr_o}, {16'hffff, 16'h5a0f, 2'h1, 28'h1234567});
        $display("hold done");
    endtask
    task automatic t_rate();
        pm.new_rate(32); // toggles stay off the system clock's rising edges
        pm.release_req();
        for (int i = 0; i < 10 && core_run !== 1'b1; i++) step();
        chk({core_run, grant}, 2'h2);
        $display("rate done");
    endtask
    task automatic t_stop();
        grant_in();
        pm.stop_clk();
        for (int i = 0; i < 100 && stopped !== 1'b1; i++) step();
        chk({stopped, grant, addr_o}, {2'h2, 28'h0fedcba});
        pm.start_clk();
        for (int i = 0; i < 57 && grant !== 1'b1; i++) step();
        chk({grant, stopped}, 2'h2);
        pm.set_req(1'b1);
        for (int i = 0; i < 10 && core_run !== 1'b1; i++) step();
        chk(core_run, 1'b1);
        $display("stop clock done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        step();
        chk({par_oe, data_oe, core_run}, {2'h3, 16'h0, 1'b1});
        t_normal();
        t_grant();
        t_flip();
        t_hold();
        t_rate();
        t_stop();
        wrap_up();
    end
endmodule // stop_clock_power_state_control_test
